// file: pmps_pkg.sv
// Package for the power state sequencer: states, register map, timing counts.
// Assumes a 25 MHz core clock and a single AHB-Lite slave port.
package pmps_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned SHUTDOWN_DELAY_US = 500;
    localparam int unsigned SHUTDOWN_CYCLES = SHUTDOWN_DELAY_US * CLK_KHZ / 1000;
    localparam int unsigned XFAIL_SYNC_US = 20;
    localparam int unsigned XFAIL_SYNC_CYCLES = XFAIL_SYNC_US * CLK_KHZ / 1000;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HOLD = 8'h04;
    localparam logic [7:0] REG_OVDB = 8'h08;
    localparam logic [7:0] REG_FLIM = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;

    // Control register bit positions.
    localparam int CTRL_QUICK_OFF = 0;
    localparam int CTRL_SW_OFF = 1;
    localparam int CTRL_OV_SDWN = 2;
    localparam int CTRL_OVLO_DIS = 3;
    localparam int CTRL_EDGE_MODE = 4;
    localparam int CTRL_XFAIL_EN = 5;

    // Reset values.
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [15:0] HOLD_RST = 16'h00FA;
    localparam logic [15:0] OVDB_RST = 16'h0019;
    localparam logic [7:0] FLIM_RST = 8'h03;

    typedef enum logic [2:0] {
        ST_LOW_POWER_OFF_STATE,
        ST_QUICK_POWERUP_OFF_STATE,
        ST_PWR_UP,
        ST_SYS_ON,
        ST_PWR_DN,
        ST_FLT_DN,
        ST_FLT_TRANS
    } pmps_state_e;

    // Analog comparator and flag inputs travel together.
    typedef struct packed {
        logic vin_above_uv;
        logic vin_above_ovlo;
        logic temp_over_limit;
        logic fuse_trim_error;
        logic fuse_config_error;
        logic selftest_error;
    } pmps_mon_s;

endpackage

// file: pmps_seq.sv
// Top-level power state sequencer with an AHB-Lite register slave.
// Assumes all pins and comparators are asynchronous to core_clk; the regulator
// sequencer reports its own progress through plain handshake inputs.
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module pmps_seq (
    input wire logic core_clk, // 25 MHz core clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hsel, // AHB slave select
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic power_on_input, // Power-on pin
    input wire logic test_mode_enable_pin, // Test-mode enable pin
    input wire logic external_fail_pin, // External fail pin, low means fail
    input wire pmps_pkg::pmps_mon_s mon, // Comparators and error flags
    input wire logic pu_reset_release, // Sequencer step that releases reset
    input wire logic pu_failure, // Failure seen during power-up
    input wire logic pd_done, // Power-down sequence finished
    input wire logic fault_timer_expired, // Fault timer expired
    input wire logic fault_event, // One fault event, counted
    output logic processor_reset_output, // Processor reset, high is released
    output logic pu_start, // Power-up sequence running
    output logic pd_start, // Power-down sequence running
    output pmps_pkg::pmps_state_e state // Current state
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] sync1_q, sync2_q, sync_d;
    logic pon_prev_q, pon_prev_d;

    always_comb begin
        sync_d = {power_on_input, test_mode_enable_pin, external_fail_pin, mon};
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
            pon_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync_d;
            sync2_q <= sync1_q;
            pon_prev_q <= pon_prev_d;
        end
    end

    logic pon, tmode, xfail_n, uv_ok, ovlo, tsd, trim_err, cfg_err, st_err;
    always_comb begin
        {pon, tmode, xfail_n, uv_ok, ovlo, tsd, trim_err, cfg_err, st_err} = sync2_q;
        pon_prev_d = pon;
    end

    logic pon_fall;
    assign pon_fall = pon_prev_q & ~pon;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [5:0] ctrl_q, ctrl_d;
    logic [15:0] hold_q, hold_d, ovdb_q, ovdb_d;
    logic [7:0] flim_q, flim_d;
    logic [7:0] fault_event_counter_q, fault_event_counter_d, sys_fault_q, sys_fault_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic sw_off_clear;

    function automatic logic [31:0] read_mux(input logic [7:0] a,
                                             input logic [5:0] c,
                                             input logic [15:0] h,
                                             input logic [15:0] o,
                                             input logic [7:0] f,
                                             input logic [20:0] s);
        logic [31:0] r;
        r = '0;
        unique case (a)
            pmps_pkg::REG_CTRL: r = {26'h0, c};
            pmps_pkg::REG_HOLD: r = {16'h0, h};
            pmps_pkg::REG_OVDB: r = {16'h0, o};
            pmps_pkg::REG_FLIM: r = {24'h0, f};
            pmps_pkg::REG_STAT: r = {11'h0, s};
            default: r = '0;
        endcase
        return r;
    endfunction

    logic take;
    assign take = hsel & hready & htrans[1];

    always_comb begin
        ctrl_d = ctrl_q;
        hold_d = hold_q;
        ovdb_d = ovdb_q;
        flim_d = flim_q;
        hrdata_d = hrdata_q;
        wr_pend_d = take & hwrite;
        wr_addr_d = take ? haddr[7:0] : wr_addr_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                pmps_pkg::REG_CTRL: ctrl_d = hwdata[5:0];
                pmps_pkg::REG_HOLD: hold_d = hwdata[15:0];
                pmps_pkg::REG_OVDB: ovdb_d = hwdata[15:0];
                pmps_pkg::REG_FLIM: flim_d = hwdata[7:0];
                default: ;
            endcase
        end
        // The hardware clear of the request is skipped when a CTRL write is pending, so a new set wins.
        if (sw_off_clear && !(wr_pend_q && wr_addr_q == pmps_pkg::REG_CTRL)) begin
            ctrl_d[pmps_pkg::CTRL_SW_OFF] = 1'b0;
        end
        if (take && !hwrite) begin
            hrdata_d = read_mux(haddr[7:0], ctrl_q, hold_q, ovdb_q, flim_q,
                                {sys_fault_q, fault_event_counter_q, 1'b0, state, processor_reset_output});
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= pmps_pkg::CTRL_RST;
            hold_q <= pmps_pkg::HOLD_RST;
            ovdb_q <= pmps_pkg::OVDB_RST;
            flim_q <= pmps_pkg::FLIM_RST;
            hrdata_q <= '0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            hold_q <= hold_d;
            ovdb_q <= ovdb_d;
            flim_q <= flim_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    logic quick_off_select, edge_mode, xfail_en, ov_sdwn, ovlo_dis;
    assign quick_off_select = ctrl_q[pmps_pkg::CTRL_QUICK_OFF];
    assign edge_mode = ctrl_q[pmps_pkg::CTRL_EDGE_MODE];
    assign xfail_en = ctrl_q[pmps_pkg::CTRL_XFAIL_EN];
    assign ov_sdwn = ctrl_q[pmps_pkg::CTRL_OV_SDWN];
    assign ovlo_dis = ctrl_q[pmps_pkg::CTRL_OVLO_DIS];

    // ----------------------------------------
    // Timers and state machine
    // ----------------------------------------
    pmps_pkg::pmps_state_e state_q, state_d;
    logic [15:0] hold_cnt_q, hold_cnt_d, ov_cnt_q, ov_cnt_d;
    logic [15:0] sd_cnt_q, sd_cnt_d;
    logic [9:0] xf_cnt_q, xf_cnt_d;
    logic hold_arm_q, hold_arm_d, rst_rel_q, rst_rel_d;

    logic env_ok, errs_ok, pu_event, pu_ok;
    always_comb begin
        env_ok = uv_ok & (~ovlo | ovlo_dis) & ~tsd;
        errs_ok = ~trim_err & ~cfg_err & ~st_err;
        pu_event = edge_mode ? pon_fall : pon;
        pu_ok = env_ok & errs_ok & (~xfail_en | xfail_n);
    end

    always_comb begin
        state_d = state_q;
        hold_cnt_d = 16'h0;
        hold_arm_d = hold_arm_q;
        ov_cnt_d = 16'h0;
        xf_cnt_d = 10'h0;
        sd_cnt_d = 16'h0;
        rst_rel_d = rst_rel_q;
        fault_event_counter_d = fault_event_counter_q;
        sys_fault_d = sys_fault_q;
        sw_off_clear = 1'b0;
        unique case (state_q)
            pmps_pkg::ST_LOW_POWER_OFF_STATE: begin
                rst_rel_d = 1'b0;
                if (quick_off_select && !tmode) begin
                    state_d = pmps_pkg::ST_QUICK_POWERUP_OFF_STATE;
                end else if (tmode) begin
                    state_d = pmps_pkg::ST_QUICK_POWERUP_OFF_STATE;
                end else if (pu_event && pu_ok) begin
                    state_d = pmps_pkg::ST_PWR_UP;
                end
            end
            pmps_pkg::ST_QUICK_POWERUP_OFF_STATE: begin
                if ((quick_off_select || tmode) && pu_event && pu_ok) begin
                    state_d = pmps_pkg::ST_PWR_UP;
                end else if (!quick_off_select && !tmode) begin
                    state_d = pmps_pkg::ST_LOW_POWER_OFF_STATE;
                end
            end
            pmps_pkg::ST_PWR_UP: begin
                fault_event_counter_d = 8'h00;
                if (pu_failure || tsd) begin
                    state_d = pmps_pkg::ST_FLT_DN;
                end else if (pu_reset_release) begin
                    rst_rel_d = 1'b1;
                    hold_arm_d = 1'b0;
                    state_d = pmps_pkg::ST_SYS_ON;
                end
            end
            pmps_pkg::ST_SYS_ON: begin
                if (fault_event && fault_event_counter_q != 8'hFF) begin
                    fault_event_counter_d = fault_event_counter_q + 8'h01;
                end
                if (pon_fall) begin
                    hold_arm_d = 1'b1;
                end else if (pon) begin
                    hold_arm_d = 1'b0;
                end
                if (hold_arm_q && !pon) begin
                    hold_cnt_d = hold_cnt_q + 16'h0001;
                end
                if (ov_sdwn && ovlo) begin
                    ov_cnt_d = ov_cnt_q + 16'h0001;
                end
                if (xfail_en && !xfail_n) begin
                    xf_cnt_d = xf_cnt_q + 10'h001;
                end
                if (ctrl_q[pmps_pkg::CTRL_SW_OFF]) begin
                    sd_cnt_d = sd_cnt_q + 16'h0001;
                end
                if (fault_timer_expired || fault_event_counter_q >= flim_q || tsd) begin
                    rst_rel_d = 1'b0;
                    state_d = pmps_pkg::ST_FLT_DN;
                end else if ((!edge_mode && !pon)
                        || (edge_mode && hold_arm_q && hold_cnt_q >= hold_q)
                        || (sd_cnt_q >= 16'(pmps_pkg::SHUTDOWN_CYCLES))
                        || (ov_cnt_q >= ovdb_q && ov_sdwn && ovlo)
                        || (xf_cnt_q >= 10'(pmps_pkg::XFAIL_SYNC_CYCLES))) begin
                    rst_rel_d = 1'b0;
                    sw_off_clear = 1'b1;
                    state_d = pmps_pkg::ST_PWR_DN;
                end
            end
            pmps_pkg::ST_PWR_DN: begin
                if (pd_done) begin
                    state_d = pmps_pkg::ST_LOW_POWER_OFF_STATE;
                end
            end
            pmps_pkg::ST_FLT_DN: begin
                rst_rel_d = 1'b0;
                if (pd_done) begin
                    state_d = pmps_pkg::ST_FLT_TRANS;
                end
            end
            pmps_pkg::ST_FLT_TRANS: begin
                sys_fault_d = sys_fault_q + 8'h01;
                state_d = pmps_pkg::ST_LOW_POWER_OFF_STATE;
            end
            default: state_d = pmps_pkg::ST_LOW_POWER_OFF_STATE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pmps_pkg::ST_LOW_POWER_OFF_STATE;
            hold_cnt_q <= '0;
            hold_arm_q <= 1'b0;
            ov_cnt_q <= '0;
            xf_cnt_q <= '0;
            sd_cnt_q <= '0;
            rst_rel_q <= 1'b0;
            fault_event_counter_q <= '0;
            sys_fault_q <= '0;
        end else begin
            state_q <= state_d;
            hold_cnt_q <= hold_cnt_d;
            hold_arm_q <= hold_arm_d;
            ov_cnt_q <= ov_cnt_d;
            xf_cnt_q <= xf_cnt_d;
            sd_cnt_q <= sd_cnt_d;
            rst_rel_q <= rst_rel_d;
            fault_event_counter_q <= fault_event_counter_d;
            sys_fault_q <= sys_fault_d;
        end
    end

    assign state = state_q;
    assign processor_reset_output = rst_rel_q;
    assign pu_start = (state_q == pmps_pkg::ST_PWR_UP);
    assign pd_start = (state_q == pmps_pkg::ST_PWR_DN) || (state_q == pmps_pkg::ST_FLT_DN);

endmodule

`default_nettype wire

// file: pmps_seq_checker.sv
// Concurrent checks on the state order and handshakes of the power state sequencer.
// Assumes it is bound to pmps_seq and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module pmps_seq_checker (
    input wire logic core_clk, // Core clock
    input wire logic rst_b, // Reset, active low
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Slave response
    input wire logic pu_reset_release, // Reset release step
    input wire logic pu_failure, // Power-up failure
    input wire logic pd_done, // Power-down finished
    input wire logic processor_reset_output, // Processor reset
    input wire logic pu_start, // Power-up running
    input wire logic pd_start, // Power-down running
    input wire pmps_pkg::pmps_state_e state // Current state
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_up_to_on: assert property (
        state == pmps_pkg::ST_PWR_UP && pu_reset_release && !pu_failure
        |=> state == pmps_pkg::ST_SYS_ON) else $error("power-up ignored reset release");
    chk_on_entry: assert property (
        state == pmps_pkg::ST_SYS_ON && $past(state) != pmps_pkg::ST_SYS_ON
        |-> $past(state) == pmps_pkg::ST_PWR_UP && processor_reset_output)
        else $error("system-on entered wrongly");
    chk_up_fail: assert property (state == pmps_pkg::ST_PWR_UP && pu_failure
        |=> state == pmps_pkg::ST_FLT_DN) else $error("power-up failure not taken");
    chk_dn_done: assert property (state == pmps_pkg::ST_PWR_DN && pd_done
        |=> state == pmps_pkg::ST_LOW_POWER_OFF_STATE) else $error("requested power-down did not end");
    chk_fault_path: assert property (state == pmps_pkg::ST_FLT_DN && pd_done
        |=> state == pmps_pkg::ST_FLT_TRANS ##1 state == pmps_pkg::ST_LOW_POWER_OFF_STATE)
        else $error("fault power-down exit wrong");
    // Leaving quick-off when both quick-off select and test mode drop is a legal way back.
    chk_off_entry: assert property (
        state == pmps_pkg::ST_LOW_POWER_OFF_STATE && $past(state) != pmps_pkg::ST_LOW_POWER_OFF_STATE
        |-> $past(state) inside {pmps_pkg::ST_PWR_DN, pmps_pkg::ST_FLT_TRANS,
            pmps_pkg::ST_QUICK_POWERUP_OFF_STATE})
        else $error("low-power off entered wrongly");
    chk_pu_decode: assert property (pu_start == (state == pmps_pkg::ST_PWR_UP))
        else $error("power-up run flag wrong");
    chk_pd_decode: assert property (pd_start == (state inside
        {pmps_pkg::ST_PWR_DN, pmps_pkg::ST_FLT_DN})) else $error("power-down run flag wrong");
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
endmodule
bind pmps_seq pmps_seq_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .hreadyout(hreadyout), .hresp(hresp), .pu_reset_release(pu_reset_release),
    .pu_failure(pu_failure), .pd_done(pd_done), .processor_reset_output(processor_reset_output),
    .pu_start(pu_start), .pd_start(pd_start), .state(state));
`default_nettype wire

// file: pmps_rail_model.sv
// Model of the regulator sequencer that answers the state sequencer's run requests.
// Assumes the bench changes latency only between sequences and failure choice only outside power-up.
`timescale 1ns/1ns
`default_nettype none
module pmps_rail_model (
    input wire logic core_clk, // Core clock
    input wire logic rst_b, // Reset, active low
    input wire logic pu_start, // Power-up running
    input wire logic pd_start, // Power-down running
    input wire logic [7:0] lat, // Cycles before each answer
    input wire logic fail_up, // Answer power-up with a failure
    output logic pu_reset_release, // Reset release step reached
    output logic pu_failure, // Failure during power-up
    output logic pd_done // Power-down finished
);
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic [7:0] cnt_q;
    logic hit;
    assign hit = (cnt_q == lat);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
        end else if (!(pu_start || pd_start) || hit) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Answers last one cycle when lat is nonzero, so a sequencer that waits a cycle too long misses them.
    assign pu_reset_release = pu_start && hit && !fail_up;
    assign pu_failure = pu_start && hit && fail_up;
    assign pd_done = pd_start && hit;
endmodule
`default_nettype wire

// file: test_pmic_power_state_machine.sv
// Self-checking bench for the power state sequencer: bus tasks, pin stimulus, state checks.
// Assumes pmps_seq with its bound checker and the rail model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_pmic_power_state_machine;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp, fail_up = 1'b0;
    logic power_on_input = 1'b0, test_mode_enable_pin = 1'b0, external_fail_pin = 1'b1;
    logic fault_timer_expired = 1'b0, fault_event = 1'b0;
    logic pu_reset_release, pu_failure, pd_done, processor_reset_output, pu_start, pd_start;
    logic [7:0] lat = 8'h03, flim;
    logic [15:0] hold;
    logic [5:0] bad [7] = '{6'h21, 6'h22, 6'h24, 6'h28, 6'h00, 6'h30, 6'h20};
    pmps_pkg::pmps_mon_s mon = 6'h20;
    pmps_pkg::pmps_state_e state;
    int fail_count = 0, checked = 0;
    always #20 core_clk = ~core_clk;
    pmps_seq u_dut (.core_clk, .rst_b, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hsel,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .power_on_input, .test_mode_enable_pin,
        .external_fail_pin, .mon, .pu_reset_release, .pu_failure, .pd_done, .fault_timer_expired,
        .fault_event, .processor_reset_output, .pu_start, .pd_start, .state);
    pmps_rail_model u_rail (.core_clk, .rst_b, .pu_start, .pd_start, .lat, .fail_up,
        .pu_reset_release, .pu_failure, .pd_done);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic rdy();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    task automatic wait_st(input pmps_pkg::pmps_state_e s, input int lim);
        int n;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        `CHK(state, s)
        if (state !== s) summarize();
    endtask
    function automatic logic [31:0] rst_val(input logic [7:0] a);
        case (a)
            pmps_pkg::REG_HOLD: return {16'h0, pmps_pkg::HOLD_RST};
            pmps_pkg::REG_OVDB: return {16'h0, pmps_pkg::OVDB_RST};
            pmps_pkg::REG_FLIM: return {24'h0, pmps_pkg::FLIM_RST};
            default: return 32'h0;
        endcase
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(49672));
        cyc(2);
        rst_b <= 1'b1;
        for (int a = 0; a <= 20; a += 4) begin
            bus(1'b0, a[7:0], 32'h0);
            `CHK(rd, rst_val(a[7:0]))
        end
        hold = 16'($urandom_range(40, 20));
        flim = 8'($urandom_range(4, 2));
        bus(1'b1, pmps_pkg::REG_HOLD, {16'h0, hold});
        bus(1'b1, pmps_pkg::REG_FLIM, {24'h0, flim});
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        bus(1'b0, pmps_pkg::REG_HOLD, 32'h0);
        `CHK(rd, {16'h0, hold})
        bus(1'b0, pmps_pkg::REG_FLIM, 32'h0);
        `CHK(rd, {24'h0, flim})
        bus(1'b0, 8'h14, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, pmps_pkg::REG_CTRL, 32'h20);
        power_on_input <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            mon <= bad[i];
            external_fail_pin <= (i < 6);
            cyc(12);
            `CHK(state, pmps_pkg::ST_LOW_POWER_OFF_STATE)
        end
        external_fail_pin <= 1'b1;
        wait_st(pmps_pkg::ST_PWR_UP, 10);
        wait_st(pmps_pkg::ST_SYS_ON, 300);
        `CHK(processor_reset_output, 1'b1)
        external_fail_pin <= 1'b0;
        cyc(pmps_pkg::XFAIL_SYNC_CYCLES - 20);
        `CHK(state, pmps_pkg::ST_SYS_ON)
        wait_st(pmps_pkg::ST_PWR_DN, 40);
        wait_st(pmps_pkg::ST_LOW_POWER_OFF_STATE, 300);
        lat <= 8'($urandom_range(40, 0));
        external_fail_pin <= 1'b1;
        wait_st(pmps_pkg::ST_SYS_ON, 300);
        power_on_input <= 1'b0;
        wait_st(pmps_pkg::ST_PWR_DN, 6);
        wait_st(pmps_pkg::ST_LOW_POWER_OFF_STATE, 300);
        bus(1'b1, pmps_pkg::REG_CTRL, 32'h11);
        wait_st(pmps_pkg::ST_QUICK_POWERUP_OFF_STATE, 10);
        power_on_input <= 1'b1;
        cyc(5);
        `CHK(state, pmps_pkg::ST_QUICK_POWERUP_OFF_STATE)
        power_on_input <= 1'b0;
        wait_st(pmps_pkg::ST_PWR_UP, 6);
        wait_st(pmps_pkg::ST_SYS_ON, 300);
        power_on_input <= 1'b1;
        cyc(5);
        power_on_input <= 1'b0;
        cyc(int'(hold) / 2);
        power_on_input <= 1'b1;
        cyc(int'(hold));
        `CHK(state, pmps_pkg::ST_SYS_ON)
        power_on_input <= 1'b0;
        cyc(int'(hold) - 2);
        `CHK(state, pmps_pkg::ST_SYS_ON)
        wait_st(pmps_pkg::ST_PWR_DN, 8);
        wait_st(pmps_pkg::ST_QUICK_POWERUP_OFF_STATE, 300);
        bus(1'b1, pmps_pkg::REG_CTRL, 32'h0);
        test_mode_enable_pin <= 1'b1;
        cyc(6);
        wait_st(pmps_pkg::ST_QUICK_POWERUP_OFF_STATE, 300);
        fail_up <= 1'b1;
        power_on_input <= 1'b1;
        wait_st(pmps_pkg::ST_PWR_UP, 8);
        wait_st(pmps_pkg::ST_FLT_DN, 300);
        test_mode_enable_pin <= 1'b0;
        fail_up <= 1'b0;
        wait_st(pmps_pkg::ST_FLT_TRANS, 300);
        wait_st(pmps_pkg::ST_LOW_POWER_OFF_STATE, 2);
        for (int k = 0; k < 3; k++) begin
            wait_st(pmps_pkg::ST_SYS_ON, 400);
            bus(1'b0, pmps_pkg::REG_STAT, 32'h0);
            `CHK(rd[20:13], 8'(k + 1))
            if (k == 0) begin
                for (int j = 0; j < int'(flim); j++) begin
                    `CHK(state, pmps_pkg::ST_SYS_ON)
                    fault_event <= 1'b1;
                    cyc(1);
                    fault_event <= 1'b0;
                    cyc(1);
                end
            end else if (k == 1) mon <= 6'h28;
            else fault_timer_expired <= 1'b1;
            wait_st(pmps_pkg::ST_FLT_DN, 8);
            mon <= 6'h20;
            fault_timer_expired <= 1'b0;
        end
        wait_st(pmps_pkg::ST_SYS_ON, 400);
        bus(1'b1, pmps_pkg::REG_CTRL, 32'h04);
        bus(1'b0, pmps_pkg::REG_STAT, 32'h0);
        `CHK(rd[20:13], 8'h04)
        mon <= 6'h30;
        cyc(int'(pmps_pkg::OVDB_RST) - 2);
        `CHK(state, pmps_pkg::ST_SYS_ON)
        wait_st(pmps_pkg::ST_PWR_DN, 10);
        mon <= 6'h20;
        wait_st(pmps_pkg::ST_SYS_ON, 400);
        bus(1'b1, pmps_pkg::REG_CTRL, 32'h02);
        cyc(pmps_pkg::SHUTDOWN_CYCLES - 20);
        `CHK(state, pmps_pkg::ST_SYS_ON)
        wait_st(pmps_pkg::ST_PWR_DN, 40);
        bus(1'b0, pmps_pkg::REG_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        summarize();
    end
endmodule
`default_nettype wire
